//--- core/ea_decode_sign_extend_saturate.sv
// Decode and execute for sign-extend-move and signed-saturate, plus EA classification.
// Assumes the fetch stage presents one opcode word with a valid strobe and,
// for non register-direct sources, the already fetched source operand.
`timescale 1ns/100ps
`include "ea_decode_map.svh"

module ea_decode_sign_extend_saturate (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Instruction from fetch
    input wire logic op_valid,
    input wire logic [15:0] op_word,
    input wire logic [31:0] mem_operand,
    // Condition codes from the datapath
    input wire logic [4:0] condition_code_reg,
    // Address register value for An-direct source
    input wire logic [31:0] src_addr_reg,
    // Decode results
    output ea_decode_pkg::ea_mode_t ea_kind_q,
    output logic [5:0] ea_cat_q,
    output logic illegal_q,
    output logic busy_q,
    // Write-back
    output logic wb_valid_q,
    output logic [2:0] dest_data_reg_q,
    output logic [31:0] wb_data_q,
    output logic [4:0] flags_out_q
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    ea_decode_pkg::ea_mode_t mode_kind;
    logic cat_data;
    logic cat_memory;
    logic cat_control;
    logic cat_alterable;
    logic cat_alt_memory;
    logic cat_data_alt;
    logic is_sxm;
    logic is_sat;
    logic sxm_src_ok;
    logic accept;

    ea_classify u_classify (
        .ea_mode(op_word[5:3]),
        .ea_reg(op_word[2:0]),
        .mode_kind(mode_kind),
        .cat_data(cat_data),
        .cat_memory(cat_memory),
        .cat_control(cat_control),
        .cat_alterable(cat_alterable),
        .cat_alt_memory(cat_alt_memory),
        .cat_data_alt(cat_data_alt)
    );

    assign is_sxm = (op_word[15:12] == `SXM_OPC_HI) && op_word[`SXM_BIT_ONE] &&
                    !op_word[`SXM_BIT_ZERO];
    assign is_sat = (op_word[15:3] == `SAT_OPC_HI);
    assign sxm_src_ok = cat_data;
    // anything else is accepted and EA-classified, but not executed
    assign accept = op_valid && !busy_q;

    // ----------------------------------------------------------------
    // Execute state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} st_t;
    st_t st_q;
    st_t st_d;
    ea_decode_pkg::op_kind_t kind_q;
    logic size_word_q;
    logic src_dreg_q;
    logic src_areg_q;
    logic [2:0] src_idx_q;
    logic [2:0] dst_idx_q;
    logic [31:0] mem_op_q;
    logic [31:0] areg_q;
    logic [4:0] flags_q;
    logic [31:0] rd_a;
    logic [31:0] rd_b;

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (accept && ((is_sxm && sxm_src_ok) || is_sat)) begin
                    st_d = ST_READ;
                end
            end
            ST_READ: begin
                st_d = ST_WRITE;
            end
            ST_WRITE: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            kind_q <= ea_decode_pkg::OP_NONE;
            size_word_q <= 1'b0;
            src_dreg_q <= 1'b0;
            src_areg_q <= 1'b0;
            src_idx_q <= 3'h0;
            dst_idx_q <= 3'h0;
            mem_op_q <= 32'h00000000;
            areg_q <= 32'h00000000;
            flags_q <= `FLAGS_RESET;
        end else if (st_q == ST_IDLE && accept) begin
            kind_q <= is_sat ? ea_decode_pkg::OP_SIGNED_SATURATE :
                      ea_decode_pkg::OP_SIGN_EXTEND_MOVE;
            size_word_q <= op_word[`SXM_SIZE_BIT];
            src_dreg_q <= (mode_kind == ea_decode_pkg::EA_DREG);
            src_areg_q <= (mode_kind == ea_decode_pkg::EA_AREG);
            src_idx_q <= op_word[2:0];
            dst_idx_q <= is_sat ? op_word[2:0] : op_word[11:9];
            mem_op_q <= mem_operand;
            areg_q <= src_addr_reg;
            flags_q <= condition_code_reg;
        end
    end

    sxm_regfile u_regfile (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(wb_valid_q),
        .wr_idx(dest_data_reg_q),
        .wr_data(wb_data_q),
        .rd_a_idx(src_idx_q),
        .rd_b_idx(dst_idx_q),
        .rd_a_q(rd_a),
        .rd_b_q(rd_b)
    );

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    logic [31:0] src_val;
    logic [31:0] sxm_res;
    logic [31:0] sat_res;
    logic sat_apply;
    logic [31:0] result;
    logic [4:0] flags_new;

    assign src_val = src_dreg_q ? rd_a : (src_areg_q ? areg_q : mem_op_q);
    assign sxm_res = size_word_q ? {{16{src_val[15]}}, src_val[15:0]} :
                     {{24{src_val[7]}}, src_val[7:0]};
    assign sat_apply = flags_q[`FLAG_V];
    assign sat_res = sat_apply ? (rd_b[31] ? `SAT_POS_MAX : `SAT_NEG_MAX) : rd_b;
    assign result = (kind_q == ea_decode_pkg::OP_SIGNED_SATURATE) ? sat_res : sxm_res;

    assign flags_new = {flags_q[`FLAG_X], result[31], (result == 32'h00000000), 1'b0, 1'b0};

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_valid_q <= 1'b0;
            dest_data_reg_q <= 3'h0;
            wb_data_q <= 32'h00000000;
            flags_out_q <= `FLAGS_RESET;
            busy_q <= 1'b0;
        end else begin
            wb_valid_q <= (st_q == ST_WRITE);
            busy_q <= (st_d != ST_IDLE);
            if (st_q == ST_WRITE) begin
                dest_data_reg_q <= dst_idx_q;
                wb_data_q <= result;
                flags_out_q <= flags_new;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ea_kind_q <= ea_decode_pkg::EA_INVALID;
            ea_cat_q <= 6'h00;
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= accept && (st_q == ST_IDLE) && is_sxm && !sxm_src_ok;
            if (accept) begin
                ea_kind_q <= mode_kind;
                ea_cat_q <= {cat_data_alt, cat_alt_memory, cat_alterable,
                             cat_control, cat_memory, cat_data};
            end
        end
    end
endmodule

//--- include/ea_decode_map.svh
// Constants for the effective-address decoder and the sign-extend / saturate unit.
// Assumes a 16-bit opcode word and 32-bit data registers in the core datapath.
`ifndef EA_DECODE_MAP_SVH
`define EA_DECODE_MAP_SVH

`define EA_MODE_DREG 3'h0
`define EA_MODE_AREG 3'h1
`define EA_MODE_IND 3'h2
`define EA_MODE_POSTINC 3'h3
`define EA_MODE_PREDEC 3'h4
`define EA_MODE_DISP16 3'h5
`define EA_MODE_INDEX8 3'h6
`define EA_MODE_EXT 3'h7

`define EA_EXT_ABS_SHORT 3'h0
`define EA_EXT_ABS_LONG 3'h1
`define EA_EXT_PC_DISP16 3'h2
`define EA_EXT_PC_INDEX8 3'h3
`define EA_EXT_IMMEDIATE 3'h4

`define SXM_OPC_HI 4'h7
`define SXM_BIT_ONE 8
`define SXM_BIT_ZERO 7
`define SXM_SIZE_BIT 6
`define SAT_OPC_HI 13'h0990

`define SAT_NEG_MAX 32'h80000000
`define SAT_POS_MAX 32'h7FFFFFFF

`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAG_X 4
`define FLAGS_RESET 5'h00

`endif

//--- include/ea_decode_pkg.sv
// Types shared by the decoder and its execute stage.
// Assumes the constants header is included by the users.
package ea_decode_pkg;
    typedef enum logic [3:0] {
        EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP16,
        EA_INDEX8, EA_PC_DISP16, EA_PC_INDEX8, EA_ABS_SHORT, EA_ABS_LONG,
        EA_IMMEDIATE, EA_INVALID
    } ea_mode_t;

    typedef enum logic [1:0] {
        OP_NONE, OP_SIGN_EXTEND_MOVE, OP_SIGNED_SATURATE, OP_ILLEGAL
    } op_kind_t;
endpackage

//--- core/ea_classify.sv
// Combinational effective-address mode decoder with category flags.
// Assumes the mode and register fields come straight from an opcode word.
`timescale 1ns/100ps
`include "ea_decode_map.svh"

module ea_classify (
    // Effective-address field
    input wire logic [2:0] ea_mode,
    input wire logic [2:0] ea_reg,
    // Decoded mode and categories
    output ea_decode_pkg::ea_mode_t mode_kind,
    output logic cat_data,
    output logic cat_memory,
    output logic cat_control,
    output logic cat_alterable,
    output logic cat_alt_memory,
    output logic cat_data_alt
);
    ea_decode_pkg::ea_mode_t ext_kind;
    logic is_reg_direct;
    logic is_ext;

    assign ext_kind = (ea_reg == `EA_EXT_ABS_SHORT) ? ea_decode_pkg::EA_ABS_SHORT :
                      (ea_reg == `EA_EXT_ABS_LONG) ? ea_decode_pkg::EA_ABS_LONG :
                      (ea_reg == `EA_EXT_PC_DISP16) ? ea_decode_pkg::EA_PC_DISP16 :
                      (ea_reg == `EA_EXT_PC_INDEX8) ? ea_decode_pkg::EA_PC_INDEX8 :
                      (ea_reg == `EA_EXT_IMMEDIATE) ? ea_decode_pkg::EA_IMMEDIATE :
                      ea_decode_pkg::EA_INVALID;

    assign mode_kind = (ea_mode == `EA_MODE_DREG) ? ea_decode_pkg::EA_DREG :
                       (ea_mode == `EA_MODE_AREG) ? ea_decode_pkg::EA_AREG :
                       (ea_mode == `EA_MODE_IND) ? ea_decode_pkg::EA_IND :
                       (ea_mode == `EA_MODE_POSTINC) ? ea_decode_pkg::EA_POSTINC :
                       (ea_mode == `EA_MODE_PREDEC) ? ea_decode_pkg::EA_PREDEC :
                       (ea_mode == `EA_MODE_DISP16) ? ea_decode_pkg::EA_DISP16 :
                       (ea_mode == `EA_MODE_INDEX8) ? ea_decode_pkg::EA_INDEX8 :
                       ext_kind;

    assign is_reg_direct = (mode_kind == ea_decode_pkg::EA_DREG) ||
                           (mode_kind == ea_decode_pkg::EA_AREG);
    assign is_ext = (ea_mode == `EA_MODE_EXT);

    assign cat_data = (mode_kind != ea_decode_pkg::EA_INVALID) &&
                      (mode_kind != ea_decode_pkg::EA_AREG);
    assign cat_memory = (mode_kind != ea_decode_pkg::EA_INVALID) && !is_reg_direct;
    assign cat_control = cat_memory &&
                         (mode_kind != ea_decode_pkg::EA_POSTINC) &&
                         (mode_kind != ea_decode_pkg::EA_PREDEC) &&
                         (mode_kind != ea_decode_pkg::EA_IMMEDIATE);
    assign cat_alterable = (mode_kind != ea_decode_pkg::EA_INVALID) && !is_ext;
    assign cat_alt_memory = cat_alterable && cat_memory;
    assign cat_data_alt = cat_data && cat_alterable;
endmodule

//--- core/sxm_regfile.sv
// Eight 32-bit data registers, one write port and two registered read ports.
// Assumes one write per cycle; read data show the state before that write.
`timescale 1ns/100ps

module sxm_regfile (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [31:0] wr_data,
    // Read ports
    input wire logic [2:0] rd_a_idx,
    input wire logic [2:0] rd_b_idx,
    output logic [31:0] rd_a_q,
    output logic [31:0] rd_b_q
);
    logic [31:0] mem_q [8];

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_reg
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    mem_q[gi] <= 32'h00000000;
                end else if (wr_en && (wr_idx == 3'(gi))) begin
                    mem_q[gi] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rd_a_q <= 32'h00000000;
            rd_b_q <= 32'h00000000;
        end else begin
            rd_a_q <= mem_q[rd_a_idx];
            rd_b_q <= mem_q[rd_b_idx];
        end
    end
endmodule

//--- tb/ea_decode_props.sv
// Checker on the top-level ports of the decode and execute block.
// Assumes single clock mclk and synchronous active-low rst_n.
`timescale 1ns/100ps

module ea_decode_props (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire logic [15:0] op_word,
    input wire logic [31:0] mem_operand,
    input wire logic [4:0] condition_code_reg,
    input wire logic busy_q,
    input wire logic illegal_q,
    input wire logic wb_valid_q,
    input wire ea_decode_pkg::ea_mode_t ea_kind_q,
    input wire logic [5:0] ea_cat_q,
    input wire logic [2:0] dest_data_reg_q,
    input wire logic [31:0] wb_data_q,
    input wire logic [4:0] flags_out_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    wire logic take = op_valid && !busy_q;
    wire logic is_sat = take && op_word[15:3] == 13'h0990;
    wire logic is_sxm = take && op_word[15:12] == 4'h7 && op_word[8] && !op_word[7];
    wire logic imm_src = op_word[5:0] == 6'h3C;

    sat_wb_delay_a: assert property (is_sat |=>
        !wb_valid_q ##1 !wb_valid_q ##1 wb_valid_q)
        else $error("saturate write-back not three cycles after accept");
    sat_busy_a: assert property (is_sat |=>
        busy_q ##1 busy_q ##1 !busy_q)
        else $error("busy does not span the saturate execution");
    sat_flags_a: assert property (is_sat && condition_code_reg[1] |-> ##3
        flags_out_q[4] == $past(condition_code_reg[4], 3) &&
        dest_data_reg_q == $past(op_word[2:0], 3))
        else $error("saturate extend flag or destination wrong");
    nz_flags_a: assert property (wb_valid_q |->
        flags_out_q[3] == wb_data_q[31] && flags_out_q[2] == (wb_data_q == 32'h0))
        else $error("negative or zero flag does not match result");
    vc_clear_a: assert property (wb_valid_q |-> flags_out_q[1:0] == 2'h0)
        else $error("overflow or carry not cleared");
    byte_ext_a: assert property (is_sxm && !op_word[6] && imm_src |-> ##3 wb_valid_q &&
        wb_data_q == {{24{$past(mem_operand[7], 3)}}, $past(mem_operand[7:0], 3)})
        else $error("byte sign extension wrong");
    word_ext_a: assert property (is_sxm && op_word[6] && imm_src |-> ##3 wb_valid_q &&
        wb_data_q == {{16{$past(mem_operand[15], 3)}}, $past(mem_operand[15:0], 3)})
        else $error("word sign extension wrong");
    illegal_src_a: assert property (is_sxm && op_word[5:3] == 3'h1 |=>
        illegal_q && !busy_q ##1 !wb_valid_q ##1 !wb_valid_q)
        else $error("address-register source not refused");
    imm_cat_a: assert property (take && imm_src |=>
        ea_kind_q == ea_decode_pkg::EA_IMMEDIATE && ea_cat_q == 6'h03)
        else $error("immediate mode decode wrong");
    combo_cat_a: assert property (ea_cat_q[5] == (ea_cat_q[0] && ea_cat_q[3]) &&
        ea_cat_q[4] == (ea_cat_q[1] && ea_cat_q[3]))
        else $error("combined categories inconsistent");
endmodule

bind ea_decode_sign_extend_saturate ea_decode_props i_props (.mclk, .rst_n, .op_valid, .op_word,
    .mem_operand, .condition_code_reg, .busy_q, .illegal_q, .wb_valid_q, .ea_kind_q, .ea_cat_q,
    .dest_data_reg_q, .wb_data_q, .flags_out_q);

//--- tb/fetch_stub.sv
// Fetch stage stand-in: holds one opcode word until the block accepts it.
// Assumes the bench pulses req for one cycle while the stub is idle.
`timescale 1ns/100ps

module fetch_stub (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic busy_q,
    input wire logic req,
    input wire logic [15:0] req_word,
    input wire logic [31:0] req_opnd,
    input wire logic [4:0] req_flags,
    output logic op_valid,
    output logic [15:0] op_word,
    output logic [31:0] mem_operand,
    output logic [31:0] src_addr_reg,
    output logic [4:0] condition_code_reg
);
    // Released fields are inverted so a late sample cannot pass by luck
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            op_valid <= 1'b0;
            op_word <= 16'h0000;
            mem_operand <= 32'h0;
            src_addr_reg <= 32'h0;
            condition_code_reg <= 5'h00;
        end else if (req) begin
            op_valid <= 1'b1;
            op_word <= req_word;
            mem_operand <= req_opnd;
            src_addr_reg <= ~req_opnd;
            condition_code_reg <= req_flags;
        end else if (op_valid && !busy_q) begin
            op_valid <= 1'b0;
            op_word <= ~op_word;
            mem_operand <= ~mem_operand;
            src_addr_reg <= ~src_addr_reg;
            condition_code_reg <= ~condition_code_reg;
        end
    end
endmodule

//--- tb/ea_decode_sign_extend_saturate_bench.sv
// Self-checking bench for the decode and execute block.
// Assumes the fetch stub supplies words; expectations come from the encodings.
`timescale 1ns/100ps

module ea_decode_sign_extend_saturate_bench;
    logic mclk, rst_n, req, op_valid, busy_q, illegal_q, wb_valid_q, got_wb, got_ill;
    logic [15:0] req_word, op_word;
    logic [31:0] req_opnd, mem_operand, src_addr_reg, wb_data_q;
    logic [4:0] req_flags, condition_code_reg, flags_out_q;
    logic [5:0] ea_cat_q;
    logic [2:0] dest_data_reg_q;
    ea_decode_pkg::ea_mode_t ea_kind_q;
    int errors, compares, cycles;

    fetch_stub i_fetch (.mclk, .rst_n, .busy_q, .req, .req_word, .req_opnd, .req_flags,
        .op_valid, .op_word, .mem_operand, .src_addr_reg, .condition_code_reg);
    ea_decode_sign_extend_saturate i_dut (.mclk, .rst_n, .op_valid, .op_word, .mem_operand,
        .condition_code_reg, .src_addr_reg, .ea_kind_q, .ea_cat_q, .illegal_q, .busy_q,
        .wb_valid_q, .dest_data_reg_q, .wb_data_q, .flags_out_q);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    // Issue one word and watch six cycles for write-back or refusal
    task automatic exec(input logic [15:0] w, input logic [31:0] opnd, input logic [4:0] flg);
        got_wb = 1'b0;
        got_ill = 1'b0;
        @(posedge mclk);
        req <= 1'b1;
        req_word <= w;
        req_opnd <= opnd;
        req_flags <= flg;
        @(posedge mclk);
        req <= 1'b0;
        repeat (6) begin
            @(posedge mclk);
            #1;
            if (wb_valid_q === 1'b1) got_wb = 1'b1;
            if (illegal_q === 1'b1) got_ill = 1'b1;
        end
    endtask

    task automatic run_wb(input logic [15:0] w, input logic [31:0] opnd, input logic [4:0] flg,
                          input logic [31:0] exp, input logic [4:0] exp_flags);
        exec(w, opnd, flg);
        chk(got_wb && !got_ill, "no write-back");
        chk(wb_data_q === exp && flags_out_q === exp_flags, "result or flags wrong");
        chk(dest_data_reg_q === w[11:9] || w[15:12] != 4'h7, "destination wrong");
        chk(dest_data_reg_q === w[2:0] || w[15:12] == 4'h7, "saturate destination wrong");
    endtask

    function automatic logic [5:0] exp_cat(input logic [5:0] ea);
        case (ea[5:3])
            3'h0: return 6'h29;
            3'h1: return 6'h08;
            3'h3, 3'h4: return 6'h3B;
            3'h7: return (ea[2:0] < 3'h4) ? 6'h07 : (ea[2:0] == 3'h4) ? 6'h03 : 6'h00;
            default: return 6'h3F;
        endcase
    endfunction

    function automatic ea_decode_pkg::ea_mode_t exp_kind(input logic [5:0] ea);
        if (ea[5:3] != 3'h7) return ea_decode_pkg::ea_mode_t'({1'b0, ea[5:3]});
        case (ea[2:0])
            3'h0: return ea_decode_pkg::EA_ABS_SHORT;
            3'h1: return ea_decode_pkg::EA_ABS_LONG;
            3'h2: return ea_decode_pkg::EA_PC_DISP16;
            3'h3: return ea_decode_pkg::EA_PC_INDEX8;
            3'h4: return ea_decode_pkg::EA_IMMEDIATE;
            default: return ea_decode_pkg::EA_INVALID;
        endcase
    endfunction

    task automatic t_modes();
        for (int m = 0; m < 64; m++) begin
            exec(16'hA000 | 16'(m), 32'h0, 5'h00);
            chk(ea_kind_q === exp_kind(6'(m)), "mode kind wrong");
            chk(ea_cat_q === exp_cat(6'(m)), "mode categories wrong");
            chk(!got_wb && !got_ill, "unknown word executed");
        end
        $display("test modes done");
    endtask

    task automatic t_sxm();
        run_wb(16'h753C, 32'h12345680, 5'h10, 32'hFFFFFF80, 5'h18);
        run_wb(16'h757C, 32'hFFFF7000, 5'h03, 32'h00007000, 5'h00);
        run_wb(16'h753C, 32'h00000100, 5'h00, 32'h00000000, 5'h04);
        run_wb(16'h757C, 32'h00018001, 5'h1F, 32'hFFFF8001, 5'h18);
        run_wb(16'h7B02, 32'hFFFFFFFF, 5'h00, 32'h00000001, 5'h00);
        exec(16'h7B0A, 32'h00000080, 5'h00);
        chk(got_ill && !got_wb, "address source not refused");
        exec(16'h7B3D, 32'h00000080, 5'h00);
        chk(got_ill && !got_wb, "invalid source not refused");
        $display("test sign extend done");
    endtask

    task automatic t_sat();
        run_wb(16'h4C85, 32'h0, 5'h10, 32'h00000001, 5'h10);
        run_wb(16'h4C85, 32'h0, 5'h13, 32'h80000000, 5'h18);
        run_wb(16'h4C85, 32'h0, 5'h02, 32'h7FFFFFFF, 5'h00);
        run_wb(16'h4C80, 32'h0, 5'h12, 32'h80000000, 5'h18);
        $display("test saturate done");
    endtask

    task automatic final_report();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run needs about 620 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        req_word = 16'h0000;
        req_opnd = 32'h0;
        req_flags = 5'h00;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        chk(ea_kind_q === ea_decode_pkg::EA_INVALID && wb_data_q === 32'h0, "reset state");
        t_modes();
        t_sxm();
        t_sat();
        final_report();
    end
endmodule
